// file: verilog/hpbp_defs.vh
`ifndef HPBP_DEFS_VH
`define HPBP_DEFS_VH

// Widths
`define HPBP_AW      5
`define HPBP_DW      8
`define HPBP_NGP     10
`define HPBP_NSY     19

// User I/O slot of each shared pin
`define HPBP_GP_A    0
`define HPBP_GP_RW   5
`define HPBP_GP_CLK  6
`define HPBP_GP_ACK  7
`define HPBP_GP_BI   8
`define HPBP_GP_IRQ  9

// Slots in the synchronised input vector
`define HPBP_SY_A    0
`define HPBP_SY_D    5
`define HPBP_SY_RW   13
`define HPBP_SY_CLK  14
`define HPBP_SY_GP   13
`define HPBP_SY_STRB 18

// Mode B address field taken from the data pins
`define HPBP_MB_DLO  2

// Pin levels
`define HPBP_ACK_A_ON 1'b1
`define HPBP_ACK_B_ON 1'b0
`define HPBP_RW_WR_A  1'b0
`define HPBP_RW_WR_B  1'b1
`define HPBP_STRB_ON  1'b0
`define HPBP_BI_ON    1'b0
`define HPBP_IRQ_ON   1'b0

// Reset values
`define HPBP_RST_BIT  1'b0
`define HPBP_RST_A    5'h00
`define HPBP_RST_D    8'h00
`define HPBP_RST_GP   10'h000
`define HPBP_RST_SY   19'h00000

`endif

// file: verilog/hpbp_sync.v
`default_nettype none
`include "hpbp_defs.vh"

module hpbp_sync
(
   // Clock and reset
   input  wire                  i_clk,
   input  wire                  i_rst_n,
   // Raw pin levels and their synchronised copy
   input  wire [`HPBP_NSY-1:0]  i_d,
   output wire [`HPBP_NSY-1:0]  o_q
);

   reg [`HPBP_NSY-1:0] meta_r;
   reg [`HPBP_NSY-1:0] sync_r;

   genvar i;
   generate
      for (i = 0; i < `HPBP_NSY; i = i + 1)
      begin : g_bit
         // First stage feeds only the second
         always @(posedge i_clk)
         begin
            if (!i_rst_n)
            begin
               meta_r[i] <= `HPBP_RST_BIT;
               sync_r[i] <= `HPBP_RST_BIT;
            end
            else
            begin
               meta_r[i] <= i_d[i];
               sync_r[i] <= meta_r[i];
            end
         end
      end
   endgenerate

   assign o_q = sync_r;

endmodule // hpbp_sync
`default_nettype wire

// file: verilog/hpbp_amap.v
`default_nettype none
`include "hpbp_defs.vh"

module hpbp_amap
(
   // Mode and sampled pins
   input  wire                  i_mode_b,
   input  wire [`HPBP_AW-1:0]   i_a,
   input  wire [`HPBP_DW-1:0]   i_d,
   // Internal register address
   output wire [`HPBP_AW-1:0]   o_addr
);

   wire [`HPBP_AW-1:0] ma_a;
   wire [`HPBP_AW-1:0] mb_a;

   // Host counts from its MSB, so the board wiring already reverses it
   assign ma_a = i_a;

   // Byte enables low, upper bits from the multiplexed bus
   assign mb_a = {i_d[`HPBP_MB_DLO+2:`HPBP_MB_DLO], i_a[1:0]};

   assign o_addr = i_mode_b ? mb_a : ma_a;

endmodule // hpbp_amap
`default_nettype wire

// file: verilog/hpbp_port.v
`default_nettype none
`include "hpbp_defs.vh"

module hpbp_port
(
   // Clock and reset
   input  wire                  I_CORE_CLK,
   input  wire                  I_RST_N,
   // Port configuration
   input  wire                  I_PORT_EN,
   input  wire                  I_MODE_B,
   // Address pins
   input  wire [`HPBP_AW-1:0]   I_A_PIN,
   output wire [`HPBP_AW-1:0]   O_A_OUT,
   output wire [`HPBP_AW-1:0]   O_A_OE,
   // Data pins
   input  wire [`HPBP_DW-1:0]   I_D_PIN,
   output wire [`HPBP_DW-1:0]   O_D_OUT,
   output wire [`HPBP_DW-1:0]   O_D_OE,
   // Read/write pin
   input  wire                  I_RW_PIN,
   output wire                  O_RW_OUT,
   output wire                  O_RW_OE,
   // Interface clock pin
   input  wire                  I_CLK_PIN,
   output wire                  O_CLK_OUT,
   output wire                  O_CLK_OE,
   // Acknowledge pin
   input  wire                  I_ACK_PIN,
   output wire                  O_ACK_OUT,
   output wire                  O_ACK_OE,
   // Burst inhibit pin
   input  wire                  I_BI_PIN,
   output wire                  O_BI_OUT,
   output wire                  O_BI_OE,
   // Interrupt request pin
   input  wire                  I_IRQ_PIN,
   output wire                  O_IRQ_OUT,
   output wire                  O_IRQ_OE,
   // Transfer strobe pin
   input  wire                  I_STRB_PIN,
   // User I/O on the shared pins
   input  wire [`HPBP_NGP-1:0]  I_GPIO_OUT,
   input  wire [`HPBP_NGP-1:0]  I_GPIO_OE,
   output wire [`HPBP_NGP-1:0]  O_GPIO_IN,
   // Internal register side
   output wire [`HPBP_AW-1:0]   O_USR_ADDR,
   output wire [`HPBP_DW-1:0]   O_USR_WDATA,
   output wire                  O_USR_WR,
   output wire                  O_USR_RD,
   input  wire [`HPBP_DW-1:0]   I_USR_RDATA,
   input  wire                  I_USR_IRQ
);

   localparam [1:0] S_IDLE = 2'h0;
   localparam [1:0] S_DATA = 2'h1;
   localparam [1:0] S_RESP = 2'h2;
   localparam [1:0] S_HOLD = 2'h3;

   // Synchronised pins
   wire [`HPBP_NSY-1:0] raw_pins;
   wire [`HPBP_NSY-1:0] sy;
   wire [`HPBP_NGP-1:0] sy_gp;
   wire [`HPBP_AW-1:0]  map_addr;
   wire [`HPBP_DW-1:0]  sy_d;

   reg                  clk_d_r;
   wire                 hclk_rise;
   wire                 strb_on;
   wire                 is_wr;

   // Transfer state
   reg [1:0]            st_r;
   reg [1:0]            st_nxt;
   reg                  wr_r;
   reg                  wr_nxt;
   reg [`HPBP_AW-1:0]   addr_r;
   reg [`HPBP_AW-1:0]   addr_nxt;
   reg [`HPBP_DW-1:0]   wdata_r;
   reg [`HPBP_DW-1:0]   wdata_nxt;
   reg                  usr_wr_r;
   reg                  usr_wr_nxt;
   reg                  usr_rd_r;
   reg                  usr_rd_nxt;
   reg                  ack_on_r;
   reg                  ack_on_nxt;
   reg [`HPBP_DW-1:0]   d_out_r;
   reg [`HPBP_DW-1:0]   d_out_nxt;
   reg                  d_oe_r;
   reg                  d_oe_nxt;

   // Shared pin drive
   reg [`HPBP_NGP-1:0]  func_out;
   reg [`HPBP_NGP-1:0]  func_oe;
   reg [`HPBP_NGP-1:0]  pin_out_r;
   reg [`HPBP_NGP-1:0]  pin_oe_r;
   reg [`HPBP_NGP-1:0]  gp_in_r;
   wire                 ack_lvl;

   assign raw_pins = {I_STRB_PIN, I_IRQ_PIN, I_BI_PIN, I_ACK_PIN, I_CLK_PIN,
                      I_RW_PIN, I_D_PIN, I_A_PIN};

   hpbp_sync u_sync
   (
      .i_clk   (I_CORE_CLK),
      .i_rst_n (I_RST_N),
      .i_d     (raw_pins),
      .o_q     (sy)
   );

   assign sy_d  = sy[`HPBP_SY_D+`HPBP_DW-1:`HPBP_SY_D];
   assign sy_gp = {sy[`HPBP_SY_GP+4:`HPBP_SY_GP], sy[`HPBP_SY_A+`HPBP_AW-1:`HPBP_SY_A]};

   hpbp_amap u_amap
   (
      .i_mode_b (I_MODE_B),
      .i_a      (sy[`HPBP_SY_A+`HPBP_AW-1:`HPBP_SY_A]),
      .i_d      (sy_d),
      .o_addr   (map_addr)
   );

   // Host clock is sampled, not used as a clock; edges lag by about two core cycles
   always @(posedge I_CORE_CLK)
   begin
      if (!I_RST_N)
         clk_d_r <= `HPBP_RST_BIT;
      else
         clk_d_r <= sy[`HPBP_SY_CLK];
   end

   assign hclk_rise = sy[`HPBP_SY_CLK] & ~clk_d_r;
   assign strb_on   = (sy[`HPBP_SY_STRB] == `HPBP_STRB_ON);

   // Write level depends on mode
   assign is_wr = I_MODE_B ? (sy[`HPBP_SY_RW] == `HPBP_RW_WR_B)
                           : (sy[`HPBP_SY_RW] == `HPBP_RW_WR_A);

   always @*
   begin
      st_nxt     = st_r;
      wr_nxt     = wr_r;
      addr_nxt   = addr_r;
      wdata_nxt  = wdata_r;
      usr_wr_nxt = 1'b0;
      usr_rd_nxt = 1'b0;
      ack_on_nxt = ack_on_r;
      d_out_nxt  = d_out_r;
      d_oe_nxt   = d_oe_r;
      if (!I_PORT_EN)
      begin
         st_nxt     = S_IDLE;
         ack_on_nxt = 1'b0;
         d_oe_nxt   = 1'b0;
      end
      else
      begin
         case (st_r)
            S_IDLE:
            begin
               // Address phase on a host clock rise while the strobe is on
               if (hclk_rise && strb_on)
               begin
                  addr_nxt = map_addr;
                  wr_nxt   = is_wr;
                  st_nxt   = S_DATA;
               end
            end
            S_DATA:
            begin
               // Data phase on the next host clock rise, both modes
               if (hclk_rise)
               begin
                  if (wr_r)
                  begin
                     wdata_nxt  = sy_d;
                     usr_wr_nxt = 1'b1;
                  end
                  else
                  begin
                     usr_rd_nxt = 1'b1;
                  end
                  st_nxt = S_RESP;
               end
            end
            S_RESP:
            begin
               // Read data is sampled while the read strobe stands
               if (!wr_r)
               begin
                  d_out_nxt = I_USR_RDATA;
                  d_oe_nxt  = 1'b1;
               end
               ack_on_nxt = 1'b1;
               st_nxt     = S_HOLD;
            end
            S_HOLD:
            begin
               // Acknowledge spans one whole host cycle
               if (hclk_rise)
               begin
                  ack_on_nxt = 1'b0;
                  d_oe_nxt   = 1'b0;
                  st_nxt     = S_IDLE;
               end
            end
            default:
            begin
               st_nxt = S_IDLE;
            end
         endcase
      end
   end

   always @(posedge I_CORE_CLK)
   begin
      if (!I_RST_N)
      begin
         st_r     <= S_IDLE;
         wr_r     <= `HPBP_RST_BIT;
         addr_r   <= `HPBP_RST_A;
         wdata_r  <= `HPBP_RST_D;
         usr_wr_r <= `HPBP_RST_BIT;
         usr_rd_r <= `HPBP_RST_BIT;
         ack_on_r <= `HPBP_RST_BIT;
         d_out_r  <= `HPBP_RST_D;
         d_oe_r   <= `HPBP_RST_BIT;
      end
      else
      begin
         st_r     <= st_nxt;
         wr_r     <= wr_nxt;
         addr_r   <= addr_nxt;
         wdata_r  <= wdata_nxt;
         usr_wr_r <= usr_wr_nxt;
         usr_rd_r <= usr_rd_nxt;
         ack_on_r <= ack_on_nxt;
         d_out_r  <= d_out_nxt;
         d_oe_r   <= d_oe_nxt;
      end
   end

   // Acknowledge polarity flips with the mode
   assign ack_lvl = I_MODE_B ? `HPBP_ACK_B_ON : `HPBP_ACK_A_ON;

   always @*
   begin
      func_out = `HPBP_RST_GP;
      func_oe  = `HPBP_RST_GP;
      // Address, read/write and clock pins stay inputs
      func_out[`HPBP_GP_ACK] = ack_on_r ? ack_lvl : ~ack_lvl;
      func_oe[`HPBP_GP_ACK]  = 1'b1;
      // Burst inhibit has no meaning in mode B, so the pin floats there
      func_out[`HPBP_GP_BI]  = `HPBP_BI_ON;
      func_oe[`HPBP_GP_BI]   = ~I_MODE_B;
      func_out[`HPBP_GP_IRQ] = I_USR_IRQ ? `HPBP_IRQ_ON : ~`HPBP_IRQ_ON;
      func_oe[`HPBP_GP_IRQ]  = 1'b1;
   end

   genvar i;
   generate
      for (i = 0; i < `HPBP_NGP; i = i + 1)
      begin : g_pin
         always @(posedge I_CORE_CLK)
         begin
            if (!I_RST_N)
            begin
               pin_out_r[i] <= `HPBP_RST_BIT;
               pin_oe_r[i]  <= `HPBP_RST_BIT;
               gp_in_r[i]   <= `HPBP_RST_BIT;
            end
            else
            begin
               // Port off hands the pin to user logic
               pin_out_r[i] <= I_PORT_EN ? func_out[i] : I_GPIO_OUT[i];
               pin_oe_r[i]  <= I_PORT_EN ? func_oe[i]  : I_GPIO_OE[i];
               gp_in_r[i]   <= sy_gp[i];
            end
         end
      end
   endgenerate

   // Outputs
   assign O_A_OUT     = pin_out_r[`HPBP_GP_A+`HPBP_AW-1:`HPBP_GP_A];
   assign O_A_OE      = pin_oe_r[`HPBP_GP_A+`HPBP_AW-1:`HPBP_GP_A];
   assign O_RW_OUT    = pin_out_r[`HPBP_GP_RW];
   assign O_RW_OE     = pin_oe_r[`HPBP_GP_RW];
   assign O_CLK_OUT   = pin_out_r[`HPBP_GP_CLK];
   assign O_CLK_OE    = pin_oe_r[`HPBP_GP_CLK];
   assign O_ACK_OUT   = pin_out_r[`HPBP_GP_ACK];
   assign O_ACK_OE    = pin_oe_r[`HPBP_GP_ACK];
   assign O_BI_OUT    = pin_out_r[`HPBP_GP_BI];
   assign O_BI_OE     = pin_oe_r[`HPBP_GP_BI];
   assign O_IRQ_OUT   = pin_out_r[`HPBP_GP_IRQ];
   assign O_IRQ_OE    = pin_oe_r[`HPBP_GP_IRQ];
   assign O_GPIO_IN   = gp_in_r;
   assign O_D_OUT     = d_out_r;
   assign O_D_OE      = {`HPBP_DW{d_oe_r}};
   assign O_USR_ADDR  = addr_r;
   assign O_USR_WDATA = wdata_r;
   assign O_USR_WR    = usr_wr_r;
   assign O_USR_RD    = usr_rd_r;

endmodule // hpbp_port
`default_nettype wire

// file: verif/hpbp_port_sva.sv
`default_nettype none
`include "hpbp_defs.vh"
module hpbp_port_sva
(
   // Clock, reset, configuration
   input wire logic       I_CORE_CLK,
   input wire logic       I_RST_N,
   input wire logic       I_PORT_EN,
   input wire logic       I_MODE_B,
   // User side
   input wire logic [9:0] I_GPIO_OE,
   input wire logic [7:0] I_USR_RDATA,
   input wire logic       I_USR_IRQ,
   input wire logic       O_USR_WR,
   input wire logic       O_USR_RD,
   // Pin drive
   input wire logic [4:0] O_A_OE,
   input wire logic       O_RW_OE,
   input wire logic       O_CLK_OE,
   input wire logic       O_ACK_OUT,
   input wire logic       O_ACK_OE,
   input wire logic       O_BI_OUT,
   input wire logic       O_BI_OE,
   input wire logic       O_IRQ_OUT,
   input wire logic       O_IRQ_OE,
   input wire logic [7:0] O_D_OUT,
   input wire logic [7:0] O_D_OE
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge I_CORE_CLK); endclocking
   default disable iff (!I_RST_N);
   sequence s_ack_a;
      (O_ACK_OUT == `HPBP_ACK_A_ON) [*2];
   endsequence
   sequence s_ack_b;
      (O_ACK_OUT == `HPBP_ACK_B_ON) [*2];
   endsequence
   property p_irq_on;
      (I_RST_N && I_PORT_EN && I_USR_IRQ) [*5] |-> O_IRQ_OE && O_IRQ_OUT == `HPBP_IRQ_ON;
   endproperty
   a_irq_on: assert property (p_irq_on) else $error("irq pin not asserted");
   property p_irq_off;
      (I_RST_N && I_PORT_EN && !I_USR_IRQ) [*5] |-> O_IRQ_OUT != `HPBP_IRQ_ON;
   endproperty
   a_irq_off: assert property (p_irq_off) else $error("irq pin stuck");
   property p_bi;
      (I_RST_N && I_PORT_EN && $stable(I_MODE_B)) [*5] |-> O_BI_OE == !I_MODE_B
         && (I_MODE_B || O_BI_OUT == `HPBP_BI_ON);
   endproperty
   a_bi: assert property (p_bi) else $error("burst inhibit wrong");
   property p_ack_a;
      (!I_MODE_B && (O_USR_WR || O_USR_RD)) |-> ##2 s_ack_a;
   endproperty
   a_ack_a: assert property (p_ack_a) else $error("mode A ack missing");
   property p_ack_b;
      (I_MODE_B && (O_USR_WR || O_USR_RD)) |-> ##2 s_ack_b;
   endproperty
   a_ack_b: assert property (p_ack_b) else $error("mode B ack missing");
   property p_rd;
      O_USR_RD |=> O_D_OE == 8'hff && O_D_OUT == $past(I_USR_RDATA);
   endproperty
   a_rd: assert property (p_rd) else $error("read data not driven");
   property p_wr;
      O_USR_WR |=> (O_D_OE == 8'h00) [*2];
   endproperty
   a_wr: assert property (p_wr) else $error("data driven on write");
   property p_pulse;
      (O_USR_WR || O_USR_RD) |-> !(O_USR_WR && O_USR_RD) ##1 !(O_USR_WR || O_USR_RD);
   endproperty
   a_pulse: assert property (p_pulse) else $error("strobe not single");
   property p_host_in;
      (I_RST_N && I_PORT_EN) [*3] |-> O_A_OE == 5'h00 && !O_RW_OE && !O_CLK_OE && O_ACK_OE;
   endproperty
   a_host_in: assert property (p_host_in) else $error("input pin driven");
   property p_user;
      (I_RST_N && !I_PORT_EN && $stable(I_GPIO_OE)) [*4] |-> O_D_OE == 8'h00
         && {O_IRQ_OE, O_BI_OE, O_ACK_OE, O_CLK_OE, O_RW_OE, O_A_OE} == I_GPIO_OE;
   endproperty
   a_user: assert property (p_user) else $error("user drive wrong");
endmodule // hpbp_port_sva
bind hpbp_port hpbp_port_sva i_sva
(
   .I_CORE_CLK(I_CORE_CLK), .I_RST_N(I_RST_N), .I_PORT_EN(I_PORT_EN), .I_MODE_B(I_MODE_B),
   .I_GPIO_OE(I_GPIO_OE), .I_USR_RDATA(I_USR_RDATA), .I_USR_IRQ(I_USR_IRQ), .O_USR_WR(O_USR_WR),
   .O_USR_RD(O_USR_RD), .O_A_OE(O_A_OE), .O_RW_OE(O_RW_OE), .O_CLK_OE(O_CLK_OE), .O_ACK_OUT(O_ACK_OUT),
   .O_ACK_OE(O_ACK_OE), .O_BI_OUT(O_BI_OUT), .O_BI_OE(O_BI_OE), .O_IRQ_OUT(O_IRQ_OUT),
   .O_IRQ_OE(O_IRQ_OE), .O_D_OUT(O_D_OUT), .O_D_OE(O_D_OE)
);
`default_nettype wire

// file: verif/hpbp_host_model.sv
`default_nettype none
module hpbp_host_model
(
   // Host bus pins
   input  wire logic       i_ack,
   input  wire logic [7:0] i_d,
   output var  logic       o_clk,
   output var  logic       o_strb_n,
   output var  logic       o_rw,
   output var  logic [4:0] o_a,
   output var  logic [7:0] o_d
);
   timeunit 1ns;
   timeprecision 1ns;
   initial
   begin
      o_clk = 1'b0;
      o_strb_n = 1'b1;
      o_rw = 1'b1;
      o_a = 5'h0a;
      o_d = 8'h96;
   end
   // Clock runs only within a transfer
   task automatic xfer(input logic mb, input logic wr, input logic [4:0] ad, input logic [7:0] wd,
                       output logic [7:0] rd, output logic ack);
      #213;
      o_strb_n = 1'b0;
      o_rw = wr ~^ mb;
      o_a = mb ? {~ad[4:2], ad[1:0]} : ad;
      o_d = mb ? {~o_d[7:5], ad[4:2], ~o_d[1:0]} : ~o_d;
      #200 o_clk = 1'b1;
      #200 o_clk = 1'b0;
      o_strb_n = 1'b1;
      o_d = wr ? wd : ~o_d; // Released lines show the inverse
      #200 o_clk = 1'b1;
      #200 o_clk = 1'b0;
      #200 o_clk = 1'b1;
      ack = i_ack;
      rd = i_d;
      #200 o_clk = 1'b0;
      o_a = ~o_a;
      o_rw = ~o_rw;
      o_d = ~o_d;
   endtask
endmodule // hpbp_host_model
`default_nettype wire

// file: verif/tb_host_processor_bus_port.sv
`default_nettype none
`include "hpbp_defs.vh"
module tb_host_processor_bus_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic       clk = 1'b0;
   logic       rst_n, port_en, mode_b, usr_irq;
   logic [9:0] gp_out, gp_oe;
   logic [2:0] ext;
   logic [7:0] usr_rdata = 8'h00;
   logic [4:0] wr_addr;
   logic [7:0] wr_data;
   int         wr_cnt = 0, num_errors = 0, checked = 0;
   wire  [4:0] a_out, a_oe, h_a, usr_addr;
   wire  [7:0] d_out, d_oe, h_d, usr_wdata;
   wire  [9:0] gp_in;
   wire        rw_out, rw_oe, ck_out, ck_oe, ack_out, ack_oe, bi_out, bi_oe, irq_out, irq_oe;
   wire        h_clk, h_strb_n, h_rw, usr_wr, usr_rd;
   wire  [4:0] a_pin = (a_oe & a_out) | (~a_oe & h_a);
   wire  [7:0] d_pin = (d_oe & d_out) | (~d_oe & h_d);
   wire        rw_pin = rw_oe ? rw_out : h_rw;
   wire        ck_pin = ck_oe ? ck_out : h_clk;
   wire        ack_pin = ack_oe ? ack_out : ext[0];
   wire        bi_pin = bi_oe ? bi_out : ext[1];
   wire        irq_pin = irq_oe ? irq_out : ext[2];
   hpbp_port i_dut
   (
      .I_CORE_CLK(clk), .I_RST_N(rst_n), .I_PORT_EN(port_en), .I_MODE_B(mode_b),
      .I_A_PIN(a_pin), .O_A_OUT(a_out), .O_A_OE(a_oe), .I_D_PIN(d_pin), .O_D_OUT(d_out), .O_D_OE(d_oe),
      .I_RW_PIN(rw_pin), .O_RW_OUT(rw_out), .O_RW_OE(rw_oe), .I_CLK_PIN(ck_pin), .O_CLK_OUT(ck_out),
      .O_CLK_OE(ck_oe), .I_ACK_PIN(ack_pin), .O_ACK_OUT(ack_out), .O_ACK_OE(ack_oe), .I_BI_PIN(bi_pin),
      .O_BI_OUT(bi_out), .O_BI_OE(bi_oe), .I_IRQ_PIN(irq_pin), .O_IRQ_OUT(irq_out), .O_IRQ_OE(irq_oe),
      .I_STRB_PIN(h_strb_n), .I_GPIO_OUT(gp_out), .I_GPIO_OE(gp_oe), .O_GPIO_IN(gp_in),
      .O_USR_ADDR(usr_addr), .O_USR_WDATA(usr_wdata), .O_USR_WR(usr_wr), .O_USR_RD(usr_rd),
      .I_USR_RDATA(usr_rdata), .I_USR_IRQ(usr_irq)
   );
   hpbp_host_model i_host
   (
      .i_ack(ack_pin), .i_d(d_pin), .o_clk(h_clk), .o_strb_n(h_strb_n), .o_rw(h_rw), .o_a(h_a), .o_d(h_d)
   );
   always #25 clk = ~clk;
   always @(negedge clk) usr_rdata <= {3'h5, usr_addr};
   always @(posedge clk)
   begin
      if (usr_wr === 1'b1)
      begin
         wr_addr <= usr_addr;
         wr_data <= usr_wdata;
         wr_cnt <= wr_cnt + 1;
      end
   end
   task automatic check(input logic [9:0] seen, input logic [9:0] exp);
      checked++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
      end
   endtask
   // Write then read back, back to back
   task automatic t_xfer(input logic mb, input logic [4:0] ad, input logic [7:0] wd);
      logic [7:0] rd;
      logic       ack;
      int         n;
      n = wr_cnt;
      i_host.xfer(mb, 1'b1, ad, wd, rd, ack);
      check(wr_addr, ad);
      check(wr_data, wd);
      check(ack, mb ? `HPBP_ACK_B_ON : `HPBP_ACK_A_ON);
      i_host.xfer(mb, 1'b0, ad, 8'h00, rd, ack);
      check(rd, {3'h5, ad});
      check(ack, mb ? `HPBP_ACK_B_ON : `HPBP_ACK_A_ON);
      check(10'(wr_cnt - n), 10'd1);
      #400;
      check(ack_pin, 1'(mb ? ~`HPBP_ACK_B_ON : ~`HPBP_ACK_A_ON));
      check(bi_oe, !mb);
      if (!mb)
         check(bi_pin, `HPBP_BI_ON);
      $display("t_xfer mode %0d addr %h done", mb, ad);
   endtask
   task automatic t_irq;
      @(negedge clk) usr_irq = 1'b1;
      repeat (4) @(negedge clk);
      check(irq_pin, `HPBP_IRQ_ON);
      usr_irq = 1'b0;
      repeat (4) @(negedge clk);
      check(irq_pin, 1'(~`HPBP_IRQ_ON));
      $display("t_irq done");
   endtask
   // Port off: shared pins follow the user drive
   task automatic t_user;
      @(negedge clk) port_en = 1'b0;
      gp_oe = 10'h2a5;
      gp_out = 10'h3c6;
      ext = 3'b101;
      repeat (6) @(negedge clk);
      check({irq_oe, bi_oe, ack_oe, ck_oe, rw_oe, a_oe}, gp_oe);
      check({irq_out, bi_out, ack_out, ck_out, rw_out, a_out} & gp_oe, gp_out & gp_oe);
      check(gp_in, (gp_oe & gp_out) | (~gp_oe & {ext, h_clk, h_rw, h_a}));
      check(d_oe, 10'h000);
      $display("t_user done");
   endtask
   task automatic print_verdict;
      $display("checks %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial
   begin
      #100000;
      num_errors++;
      print_verdict();
   end
   initial
   begin
      rst_n = 1'b0;
      port_en = 1'b1;
      mode_b = 1'b0;
      usr_irq = 1'b0;
      gp_out = 10'h000;
      gp_oe = 10'h000;
      ext = 3'b111;
      repeat (4) @(negedge clk);
      rst_n = 1'b1;
      repeat (6) @(negedge clk);
      t_xfer(1'b0, 5'h01, 8'ha5);
      t_xfer(1'b0, 5'h1e, 8'h3c);
      @(negedge clk) port_en = 1'b0;
      @(negedge clk) mode_b = 1'b1;
      @(negedge clk) port_en = 1'b1;
      repeat (6) @(negedge clk);
      t_xfer(1'b1, 5'h1d, 8'h5a);
      t_xfer(1'b1, 5'h02, 8'hc3);
      t_irq();
      t_user();
      print_verdict();
   end
endmodule // tb_host_processor_bus_port
`default_nettype wire
